// ==== hw/drs_regs.vh ====
/*
 * register map and field layout of the dma request and status block.
 * assumes a 32-bit apb bus with one register per aligned word.
 */
`ifndef DRS_REGS_VH
`define DRS_REGS_VH
`define DRS_OFS_REQ_SEL_BASE  12'h000
`define DRS_OFS_ACT_STATUS    12'h020
`define DRS_OFS_RAM_ADDR      12'h024
`define DRS_FORCE_BIT         15
`define DRS_IRQ_NUM_MSB       6
`define DRS_LAST_CH_LSB       8
`define DRS_LAST_CH_RESET     4'hf
`define DRS_REQ_SEL_RESET     16'h0000
`define DRS_RAM_ADDR_RESET    16'h0000
`endif

// ==== hw/drs_req_mux.v ====
/*
 * one channel's request selector: picks one peripheral irq line by number.
 * assumes the irq lines are already on pclk.
 */
`timescale 1ns/1ns
module drs_req_mux #(
  parameter NUM_IRQ = 128,
  parameter SEL_W   = 7
) (
  // irq lines
  input  wire [NUM_IRQ-1:0] peripheral_irq_line,
  // selection
  input  wire [SEL_W-1:0]   peripheral_irq_number,
  // selected request
  output wire               channel_transfer_request
);
  assign channel_transfer_request = peripheral_irq_line[peripheral_irq_number];
endmodule // drs_req_mux

// ==== hw/drs_dma_request_and_status.v ====
/*
 * request selection and status registers of a multi-channel dma controller.
 * assumes the transfer engine reports completions on pclk and that irq lines
 * arrive on pclk; registers are reached over apb.
 */
// The APB interface to the registers and the register addresses were decided locally.
// Overview of operation
// - software writes of zero to the force bit are ignored; only hardware clears it.
// - hardware clears the force bit when the forced transfer completes.
// - each channel holds a 7-bit irq number picking one of 128 irq lines as its request.
// - a 4-bit field reports the last active channel, reading 1111 after reset until a transfer.
// - a 16-bit register holds the most recent ram address accessed, zero after reset.
`timescale 1ns/1ns
`include "drs_regs.vh"
module drs_dma_request_and_status #(
  parameter NUM_CH  = 8,
  parameter NUM_IRQ = 128
) (
  // clock and reset
  input  wire               pclk,
  input  wire               presetn,
  // apb slave
  input  wire               psel,
  input  wire               penable,
  input  wire               pwrite,
  input  wire [11:0]        paddr,
  input  wire [31:0]        pwdata,
  output reg  [31:0]        prdata,
  output reg                pready,
  output reg                pslverr,
  // peripheral irq lines
  input  wire [NUM_IRQ-1:0] peripheral_irq_line,
  // transfer engine status
  input  wire               xfer_done,
  input  wire [2:0]         xfer_channel,
  input  wire               xfer_buffer_b,
  input  wire [15:0]        xfer_ram_addr,
  input  wire               ram_access,
  // requests to the transfer engine
  output reg  [NUM_CH-1:0]  channel_transfer_request,
  output reg  [NUM_CH-1:0]  force_transfer
);
  ////////////////////////////////////////////////////////////////////////////
  // local widths
  localparam IRQ_W  = 7;
  localparam CH_W   = 3;
  localparam LAST_W = 4;
  localparam ADDR_W = 16;
  localparam DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // storage
  reg  [IRQ_W-1:0]  irq_num_reg [0:NUM_CH-1];
  reg  [LAST_W-1:0] last_active_channel_reg;
  reg  [NUM_CH-1:0] ping_pong_buffer_status_reg;
  reg  [ADDR_W-1:0] recent_ram_address_value_reg;

  // next values
  reg  [NUM_CH-1:0] force_next;
  reg  [DATA_W-1:0] prdata_next;

  // decode
  wire [NUM_CH-1:0] sel_req;
  wire              setup_phase;
  wire              access_done;
  wire              wr_en;
  wire              rd_en;
  wire              hit_req_sel;
  wire              hit_status;
  wire              hit_ram_addr;
  wire              hit_any;
  wire [CH_W-1:0]   reg_ch;
  wire [NUM_CH-1:0] wr_ch_onehot;
  wire [NUM_CH-1:0] done_onehot;
  wire [NUM_CH-1:0] force_set;
  integer           i;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // request select words are the first eight aligned words
  function is_req_sel;
    input [11:0] a;
    begin
      is_req_sel = (a[11:5] == 7'd0) && (a[1:0] == 2'd0);
    end
  endfunction

  // one-hot channel mask from a channel number
  function [NUM_CH-1:0] ch_mask;
    input [CH_W-1:0] ch;
    begin
      ch_mask = {{(NUM_CH-1){1'b0}}, 1'b1} << ch;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  // a write lands only at the edge where the access phase sees pready high
  assign setup_phase  = psel && !penable;
  assign access_done  = psel && penable && pready;
  assign wr_en        = access_done && pwrite;
  assign rd_en        = setup_phase && !pwrite;

  assign hit_req_sel  = is_req_sel(paddr);
  assign hit_status   = (paddr == `DRS_OFS_ACT_STATUS);
  assign hit_ram_addr = (paddr == `DRS_OFS_RAM_ADDR);
  assign hit_any      = hit_req_sel || hit_status || hit_ram_addr;

  assign reg_ch       = paddr[4:2];
  assign wr_ch_onehot = ch_mask(reg_ch);

  ////////////////////////////////////////////////////////////////////////////
  // force set and clear masks
  assign done_onehot  = xfer_done ? ch_mask(xfer_channel) : {NUM_CH{1'b0}};
  assign force_set    = (wr_en && hit_req_sel && pwdata[`DRS_FORCE_BIT]) ? wr_ch_onehot
                                                                           : {NUM_CH{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // per-channel request selectors
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_mux
      drs_req_mux #(.NUM_IRQ(NUM_IRQ), .SEL_W(IRQ_W)) u_mux (
        .peripheral_irq_line      (peripheral_irq_line),
        .peripheral_irq_number    (irq_num_reg[g]),
        .channel_transfer_request (sel_req[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read data; zero outside a read so a refusal never shows stale data
  always @* begin
    prdata_next = {DATA_W{1'b0}};
    if (rd_en) begin
      if (hit_req_sel)
        prdata_next = {16'h0000, force_transfer[reg_ch], 8'h00, irq_num_reg[reg_ch]};
      else if (hit_status)
        prdata_next = {20'h0_0000, last_active_channel_reg, ping_pong_buffer_status_reg};
      else if (hit_ram_addr)
        prdata_next = {16'h0000, recent_ram_address_value_reg};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one cycle in the access phase, always zero wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase && !hit_any;
      prdata  <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // force bits
  // a software set wins over a completion in the same cycle, so a new
  // force is never lost; a written zero has no path to clear
  always @* begin
    force_next = (force_transfer & ~done_onehot) | force_set;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_transfer <= {NUM_CH{1'b0}};
    end else begin
      force_transfer <= force_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // irq number per channel
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < NUM_CH; i = i + 1)
        irq_num_reg[i] <= 7'd0;
    end else begin
      for (i = 0; i < NUM_CH; i = i + 1) begin
        if (wr_en && hit_req_sel && wr_ch_onehot[i])
          irq_num_reg[i] <= pwdata[`DRS_IRQ_NUM_MSB:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // last active channel; reads all ones until the first completion
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_active_channel_reg <= `DRS_LAST_CH_RESET;
    end else begin
      if (xfer_done)
        last_active_channel_reg <= {1'b0, xfer_channel};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ping-pong buffer status per channel
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ping_pong_buffer_status_reg <= {NUM_CH{1'b0}};
    end else begin
      for (i = 0; i < NUM_CH; i = i + 1) begin
        if (done_onehot[i])
          ping_pong_buffer_status_reg[i] <= xfer_buffer_b;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // most recent ram address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recent_ram_address_value_reg <= `DRS_RAM_ADDR_RESET;
    end else begin
      if (ram_access)
        recent_ram_address_value_reg <= xfer_ram_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // selected requests to the transfer engine, one cycle after the lines
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_transfer_request <= {NUM_CH{1'b0}};
    end else begin
      channel_transfer_request <= sel_req;
    end
  end
endmodule // drs_dma_request_and_status

// ==== testbench/drs_chk.sv ====
/* port assertions for the dma request block; assumes one pclk domain */
`timescale 1ns/1ns
module drs_chk #(parameter NUM_CH = 8) (
  input wire logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, xfer_done,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata, prdata,
  input wire logic [2:0]        xfer_channel,
  input wire logic [NUM_CH-1:0] force_transfer
);
  wire set0 = psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[15];
  wire done0 = xfer_done && xfer_channel == 3'h0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RDY: assert property (psel && !penable |=> pready) else $error("no ready");
  AST_NRDY: assert property (!psel |=> !pready) else $error("stray ready");
  AST_ONE: assert property (pready |=> !pready) else $error("long ready");
  AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("bad refusal");
  AST_HI: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper data set");
  AST_FRC: assert property (set0 |=> force_transfer[0]) else $error("force not set");
  AST_HOLD: assert property (force_transfer[0] && !done0 |=> force_transfer[0]) else $error("force lost");
  AST_CLR: assert property (force_transfer[0] && done0 && !set0 |=> !force_transfer[0]) else $error("force kept");
  cover property (set0);
  cover property (pslverr);
  cover property (done0 && force_transfer[0]);
endmodule // drs_chk
bind drs_dma_request_and_status drs_chk #(.NUM_CH(NUM_CH)) u_chk (.*);

// ==== testbench/drs_engine_model.sv ====
/* transfer engine model: ends one transfer DLY+1 cycles after a force; lowest channel first */
`timescale 1ns/1ns
module drs_engine_model #(parameter DLY = 3) (
  input wire logic        pclk, presetn,
  input wire logic [7:0]  force_transfer,
  output logic            xfer_done, xfer_buffer_b, ram_access,
  output logic [2:0]      xfer_channel,
  output logic [15:0]     xfer_ram_addr
);
  logic [3:0] cnt_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {xfer_done, xfer_buffer_b, ram_access, xfer_channel, xfer_ram_addr, cnt_reg} <= '0;
    end else begin
      {xfer_done, ram_access} <= 2'b00;
      cnt_reg <= (force_transfer != 8'h00 && !xfer_done) ? cnt_reg + 4'h1 : 4'h0;
      if (cnt_reg == DLY) begin
        for (int i = 7; i >= 0; i--) if (force_transfer[i]) xfer_channel <= 3'(i);
        {xfer_done, ram_access, xfer_buffer_b} <= {2'b11, ~xfer_buffer_b};
        xfer_ram_addr <= xfer_ram_addr + 16'h0002;
      end
    end
  end
endmodule // drs_engine_model

// ==== testbench/dma_request_and_status_tb_top.sv ====
/* top bench: apb tasks drive the block, the engine model answers forced transfers */
`timescale 1ns/1ns
module dma_request_and_status_tb_top;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic         xfer_done, xfer_buffer_b, ram_access;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, q;
  logic [127:0] peripheral_irq_line;
  logic [2:0]   xfer_channel;
  logic [15:0]  xfer_ram_addr;
  logic [7:0]   channel_transfer_request, force_transfer;
  int           err_count, checked, cyc, c;
  drs_dma_request_and_status dut (.*);
  drs_engine_model #(.DLY(8)) eng (.*);
  function automatic logic [6:0] num(int k);
    return k == 7 ? 7'h7f : 7'(k * 18);
  endfunction
  task chk(input logic [31:0] g, x);
    checked++;
    if (g !== x) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task give_verdict;
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // the whole run needs well under 400 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, peripheral_irq_line} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h020, 0);
    chk(q, 32'h0000_0f00);
    apb(0, 12'h024, 0);
    chk(q, 32'h0000_0000);
    apb(1, 12'h100, 32'h0000_ffff);
    chk({q[31:1], e}, 32'h0000_0001);
    for (c = 0; c < 8; c++) apb(1, 12'(c * 4), {25'h0, num(c)});
    for (c = 0; c < 8; c++) begin
      apb(0, 12'(c * 4), 0);
      chk(q, {25'h0, num(c)});
      peripheral_irq_line <= 128'h1 << num(c);
      repeat (3) @(posedge pclk);
      chk({24'h0, channel_transfer_request}, 32'h1 << c);
    end
    apb(1, 12'h000, 32'h0000_8000);
    apb(1, 12'h000, 32'h0000_0000);
    chk({31'h0, force_transfer[0]}, 32'h1);
    repeat (12) @(posedge pclk);
    chk({24'h0, force_transfer}, 32'h0);
    apb(0, 12'h000, 0);
    chk(q, 32'h0);
    apb(0, 12'h020, 0);
    chk(q, 32'h0000_0001);
    apb(0, 12'h024, 0);
    chk(q, 32'h0000_0002);
    give_verdict();
  end
endmodule // dma_request_and_status_tb_top
